// >>> hw/i2cmsc_pkg.sv
// Contract
// RL1: a stop sequence begins with the device driving the data line low.
// RL2: once the data line is sampled low, the device releases the clock line to float high.
// RL3: once the released clock line is sampled high, the baud counter loads from the reload register and counts to zero.
// RL4: when the baud counter expires in the stop sequence, the data line is sampled.
// RL5: a data line still low after that expiry is a bus collision.
// RL6: a clock line sampled low after release and before the data line rises is a bus collision.
// RL7: any collision sets the bus collision flag and returns the port to idle.
// RL8: a collision aborts the stop sequence, releases both lines and clears the stop enable bit.
// RL9: data sampled high while clock is high with no collision sets the stop-detected bit.
// RL10: one baud period after stop detection, the stop enable bit clears and the port flag sets.
package i2cmsc_pkg;
   localparam logic [7:0] I2CMSC_OFF_CTRL   = 8'h00;
   localparam logic [7:0] I2CMSC_OFF_BAUD   = 8'h04;
   localparam logic [7:0] I2CMSC_OFF_STATUS = 8'h08;
   localparam logic [7:0] I2CMSC_OFF_IRQ    = 8'h0c;
   localparam logic [7:0] I2CMSC_OFF_MASK   = 8'h10;
   localparam int         I2CMSC_CTRL_STOP  = 0;
   localparam int         I2CMSC_STAT_STOP  = 0;
   localparam int         I2CMSC_STAT_BUSY  = 1;
   localparam int         I2CMSC_IRQ_PORT   = 0;
   localparam int         I2CMSC_IRQ_BCOL   = 1;
   localparam logic [7:0] I2CMSC_BAUD_RST   = 8'h09;
   localparam logic [1:0] I2CMSC_MASK_RST   = 2'h0;
   localparam logic [1:0] I2CMSC_RESP_OKAY  = 2'h0;
   localparam logic [1:0] I2CMSC_RESP_SLV   = 2'h2;
   typedef enum logic [2:0] {
      I2CMSC_IDLE, I2CMSC_SDA_LOW, I2CMSC_SCL_REL, I2CMSC_COUNT, I2CMSC_SDA_REL, I2CMSC_TAIL
   } i2cmsc_state_t;
endpackage : i2cmsc_pkg

// >>> hw/i2cmsc_top.sv
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module i2cmsc_top
   import i2cmsc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   // bus lines, enable low drives low
   input  wire logic        serial_data_line_i,
   output logic             serial_data_line_o,
   output logic             serial_data_line_oe_n_o,
   input  wire logic        serial_clock_line_i,
   output logic             serial_clock_line_o,
   output logic             serial_clock_line_oe_n_o,
   // interrupt
   output logic             irq_o
);
   i2cmsc_state_t state_reg;
   logic [2:0]    sda_sync_reg;
   logic [2:0]    scl_sync_reg;
   logic          sda_reg;
   logic          scl_reg;
   logic [7:0]    baud_reload_reg;
   logic [7:0]    baud_counter_reg;
   logic          stop_sequence_enable_reg;
   logic          stop_detected_reg;
   logic [1:0]    irq_status_reg;
   logic [1:0]    irq_mask_reg;
   logic          drive_sda_low_reg;
   logic          drive_scl_low_reg;
   logic          baud_expired;
   logic          collision;
   logic          stop_seen;
   logic          tail_done;
   logic          aw_held_reg;
   logic          w_held_reg;
   logic [7:0]    awaddr_reg;
   logic [31:0]   wdata_reg;
   logic [3:0]    wstrb_reg;
   logic          wr_fire;
   logic          stop_start;

   // 3-stage sync; a level counts only when stages 2 and 3 agree
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sda_sync_reg <= 3'h7;
         scl_sync_reg <= 3'h7;
         sda_reg      <= 1'b1;
         scl_reg      <= 1'b1;
      end else begin
         sda_sync_reg <= {sda_sync_reg[1:0], serial_data_line_i};
         scl_sync_reg <= {scl_sync_reg[1:0], serial_clock_line_i};
         if (sda_sync_reg[1] == sda_sync_reg[2]) begin
            sda_reg <= sda_sync_reg[2];
         end
         if (scl_sync_reg[1] == scl_sync_reg[2]) begin
            scl_reg <= scl_sync_reg[2];
         end
      end
   end

   assign baud_expired = (baud_counter_reg == 8'h00);
   // collision cases, checked only where each one applies
   // limitation: a reload below 4 samples the data line before the sync has caught up
   assign collision = ((state_reg == I2CMSC_SDA_REL) && baud_expired && !sda_reg)    // [RL5]
                    || ((state_reg == I2CMSC_COUNT) && !scl_reg)                    // [RL6]
                    || ((state_reg == I2CMSC_SDA_REL) && !baud_expired && !scl_reg
                        && !sda_reg);                                               // [RL6]
   assign stop_seen = (state_reg == I2CMSC_SDA_REL) && baud_expired && sda_reg && scl_reg;
   assign tail_done = (state_reg == I2CMSC_TAIL) && baud_expired;

   // stop sequencer
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg         <= I2CMSC_IDLE;
         baud_counter_reg  <= 8'h00;
         drive_sda_low_reg <= 1'b0;
         drive_scl_low_reg <= 1'b0;
      end else if (collision) begin
         state_reg         <= I2CMSC_IDLE; // [RL7]
         drive_sda_low_reg <= 1'b0;        // [RL8]
         drive_scl_low_reg <= 1'b0;        // [RL8]
      end else begin
         if (!baud_expired) begin
            baud_counter_reg <= baud_counter_reg - 8'h01;
         end
         case (state_reg)
            I2CMSC_IDLE: begin
               if (stop_start) begin
                  drive_sda_low_reg <= 1'b1; // [RL1]
                  drive_scl_low_reg <= 1'b1;
                  state_reg         <= I2CMSC_SDA_LOW;
               end
            end
            I2CMSC_SDA_LOW: begin
               if (!sda_reg) begin
                  drive_scl_low_reg <= 1'b0; // [RL2]
                  state_reg         <= I2CMSC_SCL_REL;
               end
            end
            I2CMSC_SCL_REL: begin
               // stretching: wait as long as others hold the clock low
               if (scl_reg) begin
                  baud_counter_reg <= baud_reload_reg; // [RL3]
                  state_reg        <= I2CMSC_COUNT;
               end
            end
            I2CMSC_COUNT: begin
               if (baud_expired) begin
                  drive_sda_low_reg <= 1'b0;
                  baud_counter_reg  <= baud_reload_reg;
                  state_reg         <= I2CMSC_SDA_REL;
               end
            end
            I2CMSC_SDA_REL: begin
               if (stop_seen) begin // [RL4]
                  baud_counter_reg <= baud_reload_reg;
                  state_reg        <= I2CMSC_TAIL;
               end
            end
            I2CMSC_TAIL: begin
               if (baud_expired) begin
                  state_reg <= I2CMSC_IDLE;
               end
            end
            default: state_reg <= I2CMSC_IDLE;
         endcase
      end
   end

   assign serial_data_line_o       = 1'b0;
   assign serial_clock_line_o      = 1'b0;
   assign serial_data_line_oe_n_o  = !drive_sda_low_reg;
   assign serial_clock_line_oe_n_o = !drive_scl_low_reg;

   // axi write: address and data latched in either order
   assign s_axi_awready_o = !aw_held_reg && !s_axi_bvalid_o;
   assign s_axi_wready_o  = !w_held_reg && !s_axi_bvalid_o;
   assign wr_fire         = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
   assign stop_start      = (state_reg == I2CMSC_IDLE) && stop_sequence_enable_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_held_reg    <= 1'b0;
         w_held_reg     <= 1'b0;
         awaddr_reg     <= 8'h00;
         wdata_reg      <= 32'h0000_0000;
         wstrb_reg      <= 4'h0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= I2CMSC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata_i;
            wstrb_reg  <= s_axi_wstrb_i;
         end
         if (wr_fire) begin
            aw_held_reg    <= 1'b0;
            w_held_reg     <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            case (awaddr_reg)
               I2CMSC_OFF_CTRL, I2CMSC_OFF_BAUD, I2CMSC_OFF_STATUS,
               I2CMSC_OFF_IRQ, I2CMSC_OFF_MASK: s_axi_bresp_o <= I2CMSC_RESP_OKAY;
               default: s_axi_bresp_o <= I2CMSC_RESP_SLV;
            endcase
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // software registers; the stop enable bit is cleared by hardware only
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         baud_reload_reg          <= I2CMSC_BAUD_RST;
         irq_mask_reg             <= I2CMSC_MASK_RST;
         stop_sequence_enable_reg <= 1'b0;
      end else begin
         if (wr_fire && wstrb_reg[0]) begin
            if (awaddr_reg == I2CMSC_OFF_BAUD) begin
               baud_reload_reg <= wdata_reg[7:0];
            end
            if (awaddr_reg == I2CMSC_OFF_MASK) begin
               irq_mask_reg <= wdata_reg[1:0];
            end
         end
         if (collision || tail_done) begin
            stop_sequence_enable_reg <= 1'b0; // [RL8] [RL10]
         end else if (wr_fire && wstrb_reg[0] && awaddr_reg == I2CMSC_OFF_CTRL
                      && wdata_reg[I2CMSC_CTRL_STOP]) begin
            stop_sequence_enable_reg <= 1'b1;
         end
      end
   end

   // sticky flags; interrupt flags are write one to clear, stop-detected clears when the next stop starts; a set in the same cycle wins
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_status_reg    <= 2'h0;
         stop_detected_reg <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_fire && wstrb_reg[0] && awaddr_reg == I2CMSC_OFF_IRQ && wdata_reg[i]) begin
               irq_status_reg[i] <= 1'b0;
            end
         end
         if (collision) begin
            irq_status_reg[I2CMSC_IRQ_BCOL] <= 1'b1; // [RL7]
         end
         if (tail_done) begin
            irq_status_reg[I2CMSC_IRQ_PORT] <= 1'b1; // [RL10]
         end
         if (stop_seen && !collision) begin
            stop_detected_reg <= 1'b1; // [RL9]
         end else if (stop_start) begin
            stop_detected_reg <= 1'b0;
         end
      end
   end

   assign irq_o = |(irq_status_reg & irq_mask_reg);

   // axi read
   assign s_axi_arready_o = !s_axi_rvalid_o;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= I2CMSC_RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rresp_o  <= I2CMSC_RESP_OKAY;
         case (s_axi_araddr_i)
            I2CMSC_OFF_CTRL:   s_axi_rdata_o <= {31'h0, stop_sequence_enable_reg};
            I2CMSC_OFF_BAUD:   s_axi_rdata_o <= {24'h0, baud_reload_reg};
            I2CMSC_OFF_STATUS: s_axi_rdata_o <= {30'h0, state_reg != I2CMSC_IDLE,
                                                 stop_detected_reg};
            I2CMSC_OFF_IRQ:    s_axi_rdata_o <= {30'h0, irq_status_reg};
            I2CMSC_OFF_MASK:   s_axi_rdata_o <= {30'h0, irq_mask_reg};
            default: begin
               s_axi_rdata_o <= 32'h0000_0000;
               s_axi_rresp_o <= I2CMSC_RESP_SLV;
            end
         endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // checks
   a_start_drives_sda: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL1]
      stop_start && !collision |=> !serial_data_line_oe_n_o) else $error("stop start no sda");
   a_scl_released: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL2]
      state_reg == I2CMSC_SDA_LOW && !sda_reg |=> serial_clock_line_oe_n_o)
      else $error("scl not released");
   a_baud_loaded: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL3]
      state_reg == I2CMSC_SCL_REL && scl_reg |=> baud_counter_reg == $past(baud_reload_reg))
      else $error("baud not loaded");
   a_sda_low_coll: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL4] [RL5] [RL7]
      state_reg == I2CMSC_SDA_REL && baud_expired && !sda_reg
      |=> irq_status_reg[I2CMSC_IRQ_BCOL] && state_reg == I2CMSC_IDLE)
      else $error("case 1 missed");
   a_scl_low_coll: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL6]
      state_reg == I2CMSC_COUNT && !scl_reg |=> irq_status_reg[I2CMSC_IRQ_BCOL])
      else $error("case 2 missed");
   a_abort_release: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL8]
      collision |=> serial_data_line_oe_n_o && serial_clock_line_oe_n_o
      && !stop_sequence_enable_reg) else $error("abort incomplete");
   a_stop_detect: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL9]
      stop_seen |=> stop_detected_reg && state_reg == I2CMSC_TAIL)
      else $error("stop not detected");
   a_tail_finish: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL10]
      $rose(stop_detected_reg) |-> ##[1:256] irq_status_reg[I2CMSC_IRQ_PORT]
      && !stop_sequence_enable_reg) else $error("tail not done");
   c_clean_stop: cover property (@(posedge mclk_i) disable iff (!rst_n_i) tail_done);
   c_coll_case1: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      state_reg == I2CMSC_SDA_REL && collision);
   c_coll_case2: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      state_reg == I2CMSC_COUNT && collision);
endmodule : i2cmsc_top

// >>> tb/i2cmsc_bus_model.sv
`timescale 1ns/1ps
module i2cmsc_bus_model (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   // device enables, low drives low
   input  wire logic       dev_sda_oe_n_i,
   input  wire logic       dev_scl_oe_n_i,
   // other parties on the bus
   input  wire logic       hold_sda_i,
   input  wire logic       grab_scl_i,
   input  wire logic [7:0] stretch_i,
   // wired levels
   output logic            sda_o,
   output logic            scl_o
);
   logic       scl_oe_n_reg;
   logic [7:0] stretch_reg;
   logic       rel_now;

   // stretch starts in the very cycle of release, else a one-cycle high glitch
   assign rel_now = dev_scl_oe_n_i & ~scl_oe_n_reg & (stretch_i != 8'h00);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_oe_n_reg <= 1'b1;
         stretch_reg  <= 8'h00;
      end else begin
         scl_oe_n_reg <= dev_scl_oe_n_i;
         if (dev_scl_oe_n_i && !scl_oe_n_reg) stretch_reg <= stretch_i;
         else if (stretch_reg != 8'h00) stretch_reg <= stretch_reg - 8'h01;
      end
   end

   // released lines float high through the pull-ups
   assign sda_o = dev_sda_oe_n_i & ~hold_sda_i;
   assign scl_o = dev_scl_oe_n_i & ~grab_scl_i & (stretch_reg == 8'h00) & ~rel_now;
endmodule : i2cmsc_bus_model

// >>> tb/i2cmsc_tb_top.sv
`timescale 1ns/1ps
module i2cmsc_tb_top
   import i2cmsc_pkg::*;
;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, stretch = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp;
   logic        sda, scl, sda_oe_n, scl_oe_n, sda_out, scl_out;
   logic        hold_sda = 1'b0, grab_scl = 1'b0;
   int          n_fail = 0, tests_run = 0;

   always #50 mclk = ~mclk;

   i2cmsc_top i2cmsc_top_i (
      .mclk_i(mclk), .rst_n_i(rst_n),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .serial_data_line_i(sda), .serial_data_line_o(sda_out),
      .serial_data_line_oe_n_o(sda_oe_n),
      .serial_clock_line_i(scl), .serial_clock_line_o(scl_out),
      .serial_clock_line_oe_n_o(scl_oe_n),
      .irq_o(irq));

   i2cmsc_bus_model i2cmsc_bus_model_i (
      .mclk_i(mclk), .rst_n_i(rst_n), .dev_sda_oe_n_i(sda_oe_n), .dev_scl_oe_n_i(scl_oe_n),
      .hold_sda_i(hold_sda), .grab_scl_i(grab_scl), .stretch_i(stretch),
      .sda_o(sda), .scl_o(scl));

   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask : check

   task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge mclk);
         if (awvalid && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      check(bresp, er, "write response");
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge mclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge mclk); while (rvalid !== 1'b1);
      v = rdata;
      rready <= 1'b0;
      check(rresp, er, "read response");
   endtask : rd

   function automatic logic pin(input int which);
      case (which)
         0: pin = sda_oe_n;
         1: pin = scl_oe_n;
         default: pin = irq;
      endcase
   endfunction : pin

   task wait_pin(input int which, input logic v);
      int n;
      n = 0;
      while (pin(which) !== v && n < 400) begin
         @(posedge mclk);
         n++;
      end
      check(pin(which), v, "pin level");
   endtask : wait_pin

   // start a stop and follow it until the clock line is let go
   task run_stop;
      wr(I2CMSC_OFF_CTRL, 32'h1, I2CMSC_RESP_OKAY);
      wait_pin(0, 1'b0);
      wait_pin(1, 1'b0);
      wait_pin(1, 1'b1);
      check(sda, 1'b0, "data low at clock release");
   endtask : run_stop

   task poll_irq;
      int n;
      n = 0;
      do begin
         rd(I2CMSC_OFF_IRQ, d, I2CMSC_RESP_OKAY);
         n++;
      end while (d[1:0] === 2'b00 && n < 100);
   endtask : poll_irq

   // collision ending: flag, lines released, enable cleared
   task collided;
      wait_pin(2, 1'b1);
      rd(I2CMSC_OFF_IRQ, d, I2CMSC_RESP_OKAY);
      check(d, 32'h2, "collision flag only");
      rd(I2CMSC_OFF_CTRL, d, I2CMSC_RESP_OKAY);
      check(d, 32'h0, "stop enable cleared");
      check({sda_oe_n, scl_oe_n}, 2'b11, "lines released");
      wr(I2CMSC_OFF_IRQ, 32'h2, I2CMSC_RESP_OKAY);
   endtask : collided

   task wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   // generous span: four stops of a few tens of cycles each
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      wrap_up();
   end

   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      check({sda_oe_n, scl_oe_n, irq}, 3'b110, "reset pins");
      check({sda_out, scl_out}, 2'b00, "lines drive only low");
      rd(I2CMSC_OFF_BAUD, d, I2CMSC_RESP_OKAY);
      check(d, {24'h0, I2CMSC_BAUD_RST}, "baud reset");
      rd(I2CMSC_OFF_MASK, d, I2CMSC_RESP_OKAY);
      check(d, {30'h0, I2CMSC_MASK_RST}, "mask reset");
      rd(8'h14, d, I2CMSC_RESP_SLV);
      check(d, 32'h0, "unmapped read");
      wr(8'h14, 32'h1, I2CMSC_RESP_SLV);
      wr(I2CMSC_OFF_BAUD, 32'h5, I2CMSC_RESP_OKAY);
      // clean stop, interrupt masked
      run_stop();
      poll_irq();
      check(d, 32'h1, "port flag after stop");
      check(irq, 1'b0, "masked interrupt");
      rd(I2CMSC_OFF_STATUS, d, I2CMSC_RESP_OKAY);
      check(d[0], 1'b1, "stop detected");
      rd(I2CMSC_OFF_CTRL, d, I2CMSC_RESP_OKAY);
      check(d, 32'h0, "stop enable cleared");
      wr(I2CMSC_OFF_MASK, 32'h3, I2CMSC_RESP_OKAY);
      wait_pin(2, 1'b1);
      wr(I2CMSC_OFF_IRQ, 32'h1, I2CMSC_RESP_OKAY);
      wait_pin(2, 1'b0);
      // another party stretches the clock
      stretch <= 8'd20;
      run_stop();
      repeat (15) @(posedge mclk);
      check(sda_oe_n, 1'b0, "data held during stretch");
      rd(I2CMSC_OFF_STATUS, d, I2CMSC_RESP_OKAY);
      check(d, 32'h2, "busy during stretch");
      stretch <= 8'h00;
      poll_irq();
      check(d, 32'h1, "stop after stretch");
      wr(I2CMSC_OFF_IRQ, 32'h1, I2CMSC_RESP_OKAY);
      // another master keeps data low
      hold_sda <= 1'b1;
      run_stop();
      collided();
      rd(I2CMSC_OFF_STATUS, d, I2CMSC_RESP_OKAY);
      check(d[0], 1'b0, "no stop detected");
      hold_sda <= 1'b0;
      // another master pulls the clock low mid-count
      wr(I2CMSC_OFF_BAUD, 32'h9, I2CMSC_RESP_OKAY);
      run_stop();
      repeat (6) @(posedge mclk);
      grab_scl <= 1'b1;
      collided();
      grab_scl <= 1'b0;
      wrap_up();
   end
endmodule : i2cmsc_tb_top
